//--- hw/tsi_pkg.sv
package tsi_pkg;
   // system and serial timing
   localparam int CLOCK_KHZ = 50000;
   localparam int SERIAL_CLOCK_KHZ = 4096;
   localparam int SERIAL_BIT_KBPS = 2048;
   localparam int SERIAL_HALF_CYCLES = CLOCK_KHZ / (2 * SERIAL_CLOCK_KHZ);
   localparam int FRAME_US = 125;

   // frame organisation
   localparam int STREAMS = 4;
   localparam int CHANNELS = 32;
   localparam int BITS = 8;
   localparam int COUNT_W = 9;
   localparam int MEM_DEPTH = STREAMS * CHANNELS;
   localparam int MEM_AW = 7;

   // serial-side memory traffic steps within one channel slot
   localparam logic [3:0] STEP_F0 = 4'h0;
   localparam logic [3:0] STEP_W0 = 4'h1;
   localparam logic [3:0] STEP_F1 = 4'h2;
   localparam logic [3:0] STEP_F2 = 4'h3;
   localparam logic [3:0] STEP_W1 = 4'h4;
   localparam logic [3:0] STEP_F3 = 4'h5;
   localparam logic [3:0] STEP_W2 = 4'h6;
   localparam logic [3:0] STEP_W3 = 4'h7;
   localparam logic [3:0] STEP_FREE = 4'h8;
   localparam logic [3:0] STEP_LAST = 4'hF;
   localparam logic [3:0] STEP_FIRST = 4'h0;

   // control register layout
   localparam int CTRL_SPLIT_BIT = 7;
   localparam int CTRL_PE_BIT = 6;
   localparam int CTRL_MS_HI = 4;
   localparam int CTRL_MS_LO = 3;
   localparam int CTRL_STA_HI = 1;
   localparam int CTRL_STA_LO = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] MS_DATA = 2'h1;
   localparam logic [1:0] MS_LOW = 2'h2;
   localparam logic [1:0] MS_HIGH = 2'h3;

   // high connection byte and address fields
   localparam int HIGH_PROC_BIT = 2;
   localparam int HIGH_OE_BIT = 0;
   localparam int ADDR_MEM_BIT = 5;
   localparam int SRC_STREAM_HI = 6;
   localparam int SRC_STREAM_LO = 5;
   localparam int SRC_CHAN_HI = 4;

   typedef enum logic [2:0] {
      TSI_DEV_IDLE = 3'b001,
      TSI_DEV_WAIT = 3'b010,
      TSI_DEV_ACK = 3'b100
   } tsi_dev_state_type;

   typedef enum logic [3:0] {
      TSI_HOST_IDLE = 4'b0001,
      TSI_HOST_SETUP = 4'b0010,
      TSI_HOST_STROBE = 4'b0100,
      TSI_HOST_RELEASE = 4'b1000
   } tsi_host_state_type;
endpackage

//--- hw/tsi_bus_if.sv
`timescale 1ns/100ps
interface tsi_bus_if;
   // serial link
   logic serial_clock;
   logic frame_pulse_n;
   logic [3:0] serial_in;
   logic [3:0] serial_out;
   logic [3:0] serial_out_en;
   logic master_drive_enable;
   // processor port
   logic data_strobe;
   logic chip_select_n;
   logic read_write;
   logic [5:0] address;
   logic [7:0] host_data;
   logic host_data_en;
   logic [7:0] dev_data;
   logic dev_data_en;
   logic transfer_ack_n;
   logic transfer_ack_n_en;

   modport device (
      input serial_clock, frame_pulse_n, serial_in, master_drive_enable,
      input data_strobe, chip_select_n, read_write, address, host_data, host_data_en,
      output serial_out, serial_out_en, dev_data, dev_data_en, transfer_ack_n, transfer_ack_n_en
   );
   modport host (
      output serial_clock, frame_pulse_n, serial_in, master_drive_enable,
      output data_strobe, chip_select_n, read_write, address, host_data, host_data_en,
      input serial_out, serial_out_en, dev_data, dev_data_en, transfer_ack_n, transfer_ack_n_en
   );
endinterface

//--- hw/tsi_switch_device.sv
`timescale 1ns/100ps
module tsi_switch_device import tsi_pkg::*; (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // link to the far end
   tsi_bus_if.device bus,
   // status
   output logic frame_start_out,
   output logic [7:0] control_out
);
   logic c4_s1, c4_s2, c4_s3;
   logic fp_s1, fp_s2;
   logic mde_s1, mde_s2;
   logic ds_s1, ds_s2;
   logic cs_s1, cs_s2;
   logic [STREAMS-1:0] rx_s1, rx_s2;
   logic [COUNT_W-1:0] half_count;
   logic [COUNT_W-1:0] next_count;
   logic rise;
   logic [3:0] step;
   logic [2:0] bit_idx;
   logic [4:0] channel;
   logic [4:0] prev_channel;
   logic [4:0] fetch_channel;
   logic [3:0] op;
   logic [7:0] data_mem [MEM_DEPTH];
   logic [7:0] conn_low [MEM_DEPTH];
   logic [7:0] conn_high [MEM_DEPTH];
   logic [7:0] rx_shift [STREAMS];
   logic [7:0] rx_hold [STREAMS];
   logic [7:0] out_next [STREAMS];
   logic [7:0] out_shift [STREAMS];
   logic [STREAMS-1:0] out_next_en;
   logic [STREAMS-1:0] out_chan_en;
   logic [7:0] fetch_high;
   logic [7:0] fetch_low;
   logic fetch_proc;
   logic fetch_en;
   logic [7:0] fetch_byte;
   logic [7:0] ctrl;
   tsi_dev_state_type state;
   logic req;
   logic acc_read;
   logic [5:0] acc_addr;
   logic [7:0] acc_wdata;
   logic [7:0] rd_data;
   logic mem_go;
   logic [MEM_AW-1:0] acc_index;
   logic [1:0] acc_sel;
   logic [7:0] mem_rd;

   // {write, fetch, stream}; order sets which stream pairs reach two slots
   function automatic logic [3:0] slot_op(input logic [3:0] s);
      logic [3:0] r;
      r = 4'h0;
      case (s)
         STEP_W0: r = 4'h8;
         STEP_F0: r = 4'h4;
         STEP_F1: r = 4'h5;
         STEP_F2: r = 4'h6;
         STEP_W1: r = 4'h9;
         STEP_F3: r = 4'h7;
         STEP_W2: r = 4'hA;
         STEP_W3: r = 4'hB;
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   // pins are asynchronous to clk_in
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         c4_s1 <= 1'b0;
         c4_s2 <= 1'b0;
         c4_s3 <= 1'b0;
         fp_s1 <= 1'b1;
         fp_s2 <= 1'b1;
         mde_s1 <= 1'b0;
         mde_s2 <= 1'b0;
         ds_s1 <= 1'b0;
         ds_s2 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         rx_s1 <= '0;
         rx_s2 <= '0;
      end else begin
         c4_s1 <= bus.serial_clock;
         c4_s2 <= c4_s1;
         c4_s3 <= c4_s2;
         fp_s1 <= bus.frame_pulse_n;
         fp_s2 <= fp_s1;
         mde_s1 <= bus.master_drive_enable;
         mde_s2 <= mde_s1;
         ds_s1 <= bus.data_strobe;
         ds_s2 <= ds_s1;
         cs_s1 <= bus.chip_select_n;
         cs_s2 <= cs_s1;
         rx_s1 <= bus.serial_in;
         rx_s2 <= rx_s1;
      end
   end

   assign rise = c4_s2 & ~c4_s3;
   assign next_count = fp_s2 ? COUNT_W'(half_count + 9'h001) : '0;
   assign step = next_count[3:0];
   assign bit_idx = next_count[3:1];
   assign channel = next_count[8:4];
   assign prev_channel = 5'(channel - 5'h01);
   assign fetch_channel = 5'(channel + 5'h01);
   assign op = rise ? slot_op(step) : 4'h0;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         half_count <= '0;
         frame_start_out <= 1'b0;
      end else begin
         frame_start_out <= rise & ~fp_s2;
         if (rise) begin
            half_count <= next_count;
         end
      end
   end

   // serial to parallel, sampled in the second half of each bit
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int s = 0; s < STREAMS; s++) begin
            rx_shift[s] <= 8'h00;
            rx_hold[s] <= 8'h00;
         end
      end else if (rise && next_count[0]) begin
         for (int s = 0; s < STREAMS; s++) begin
            rx_shift[s] <= {rx_shift[s][6:0], rx_s2[s]};
            if (step == STEP_LAST) begin
               rx_hold[s] <= {rx_shift[s][6:0], rx_s2[s]};
            end
         end
      end
   end

   // bytes of slot n land in memory during slot n+1
   always_ff @(posedge clk_in) begin
      if (op[3]) begin
         data_mem[{op[1:0], prev_channel}] <= rx_hold[op[1:0]];
      end
   end

   assign fetch_high = conn_high[{op[1:0], fetch_channel}];
   assign fetch_low = conn_low[{op[1:0], fetch_channel}];
   assign fetch_proc = fetch_high[HIGH_PROC_BIT] | ctrl[CTRL_PE_BIT];
   assign fetch_en = fetch_high[HIGH_OE_BIT] | ctrl[CTRL_PE_BIT];
   // any output may name any source, so one input can feed many outputs
   assign fetch_byte = fetch_proc ? fetch_low : data_mem[fetch_low[SRC_STREAM_HI:0]];

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         out_next_en <= '0;
         out_chan_en <= '0;
         bus.serial_out <= '0;
         bus.serial_out_en <= '0;
         for (int s = 0; s < STREAMS; s++) begin
            out_next[s] <= 8'h00;
            out_shift[s] <= 8'h00;
         end
      end else begin
         for (int s = 0; s < STREAMS; s++) begin
            bus.serial_out_en[s] <= mde_s2 & out_chan_en[s];
         end
         if (op[2]) begin
            out_next[op[1:0]] <= fetch_byte;
            out_next_en[op[1:0]] <= fetch_en;
         end
         if (rise && !next_count[0]) begin
            for (int s = 0; s < STREAMS; s++) begin
               if (step == STEP_FIRST) begin
                  out_shift[s] <= out_next[s];
                  out_chan_en[s] <= out_next_en[s];
                  bus.serial_out[s] <= out_next[s][BITS-1];
               end else begin
                  bus.serial_out[s] <= out_shift[s][3'(BITS - 1) - bit_idx];
               end
            end
         end
      end
   end

   // processor port
   assign req = ds_s2 & ~cs_s2;
   assign mem_go = (state == TSI_DEV_WAIT) && req && rise && (step >= STEP_FREE);
   assign acc_index = {ctrl[CTRL_STA_HI:CTRL_STA_LO], acc_addr[SRC_CHAN_HI:0]};
   assign acc_sel = ctrl[CTRL_MS_HI:CTRL_MS_LO];

   always_comb begin
      mem_rd = 8'h00;
      if (ctrl[CTRL_SPLIT_BIT]) begin
         mem_rd = data_mem[acc_index];
      end else begin
         case (acc_sel)
            MS_DATA: mem_rd = data_mem[acc_index];
            MS_LOW: mem_rd = conn_low[acc_index];
            MS_HIGH: mem_rd = conn_high[acc_index];
            default: mem_rd = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (mem_go && !acc_read) begin
         if (ctrl[CTRL_SPLIT_BIT] || acc_sel == MS_LOW) begin
            conn_low[acc_index] <= acc_wdata;
         end else if (acc_sel == MS_HIGH) begin
            conn_high[acc_index] <= acc_wdata;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= TSI_DEV_IDLE;
         ctrl <= CTRL_RESET;
         acc_read <= 1'b0;
         acc_addr <= 6'h00;
         acc_wdata <= 8'h00;
         rd_data <= 8'h00;
      end else begin
         case (state)
            TSI_DEV_IDLE: begin
               if (req) begin
                  acc_read <= bus.read_write;
                  acc_addr <= bus.address;
                  acc_wdata <= bus.host_data;
                  if (!bus.address[ADDR_MEM_BIT]) begin
                     // register access needs no memory slot
                     if (bus.read_write) begin
                        rd_data <= ctrl;
                     end else begin
                        ctrl <= bus.host_data;
                     end
                     state <= TSI_DEV_ACK;
                  end else begin
                     state <= TSI_DEV_WAIT;
                  end
               end
            end
            TSI_DEV_WAIT: begin
               if (!req) begin
                  state <= TSI_DEV_IDLE;
               end else if (mem_go) begin
                  rd_data <= mem_rd;
                  state <= TSI_DEV_ACK;
               end
            end
            TSI_DEV_ACK: begin
               if (!req) begin
                  state <= TSI_DEV_IDLE;
               end
            end
            default: state <= TSI_DEV_IDLE;
         endcase
      end
   end

   assign bus.transfer_ack_n = 1'b0;
   assign bus.transfer_ack_n_en = (state == TSI_DEV_ACK);
   assign bus.dev_data = rd_data;
   assign bus.dev_data_en = (state == TSI_DEV_ACK) && acc_read && req;
   assign control_out = ctrl;
endmodule

//--- hw/tsi_switch_host.sv
`timescale 1ns/100ps
module tsi_switch_host import tsi_pkg::*; #(
   parameter int HALF_CYCLES = SERIAL_HALF_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // link to the device
   tsi_bus_if.host bus,
   // processor commands
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic [5:0] cmd_addr_in,
   input wire logic [7:0] cmd_wdata_in,
   output logic cmd_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_rdata_out,
   // serial user side
   input wire logic drive_enable_in,
   input wire logic [31:0] stream_data_in,
   output logic slot_start_out,
   output logic [31:0] rx_data_out,
   output logic [3:0] rx_enabled_out,
   output logic [4:0] rx_channel_out,
   output logic rx_valid_out
);
   logic [7:0] div_count;
   logic host_rise;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] next_count;
   logic [7:0] tx_shift [STREAMS];
   logic [7:0] rx_shift [STREAMS];
   logic [STREAMS-1:0] rx_en_acc;
   logic [STREAMS-1:0] so_s1, so_s2, soe_s1, soe_s2;
   logic ack_s1, ack_s2;
   tsi_host_state_type state;

   // the host makes the serial clock by dividing clk_in; rate is approximate
   assign host_rise = (div_count == 8'(HALF_CYCLES - 1)) && !bus.serial_clock;
   assign next_count = COUNT_W'(count + 9'h001);
   assign slot_start_out = host_rise && (next_count[3:0] == STEP_FIRST);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         div_count <= 8'h00;
         bus.serial_clock <= 1'b0;
         bus.frame_pulse_n <= 1'b1;
         count <= '1;
      end else begin
         if (div_count == 8'(HALF_CYCLES - 1)) begin
            div_count <= 8'h00;
            bus.serial_clock <= ~bus.serial_clock;
         end else begin
            div_count <= 8'(div_count + 8'h01);
         end
         if (host_rise) begin
            count <= next_count;
            bus.frame_pulse_n <= (next_count != '0);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         so_s1 <= '0;
         so_s2 <= '0;
         soe_s1 <= '0;
         soe_s2 <= '0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         so_s1 <= bus.serial_out;
         so_s2 <= so_s1;
         soe_s1 <= bus.serial_out_en;
         soe_s2 <= soe_s1;
         ack_s1 <= bus.transfer_ack_n_en;
         ack_s2 <= ack_s1;
      end
   end

   // transmit toward the device, receive from it, msb first
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         bus.serial_in <= '0;
         bus.master_drive_enable <= 1'b0;
         rx_data_out <= 32'h00000000;
         rx_enabled_out <= 4'h0;
         rx_channel_out <= 5'h00;
         rx_valid_out <= 1'b0;
         rx_en_acc <= '0;
         for (int s = 0; s < STREAMS; s++) begin
            tx_shift[s] <= 8'h00;
            rx_shift[s] <= 8'h00;
         end
      end else begin
         bus.master_drive_enable <= drive_enable_in;
         rx_valid_out <= 1'b0;
         if (host_rise && !next_count[0]) begin
            for (int s = 0; s < STREAMS; s++) begin
               if (next_count[3:0] == STEP_FIRST) begin
                  tx_shift[s] <= stream_data_in[s*BITS +: BITS];
                  bus.serial_in[s] <= stream_data_in[s*BITS + BITS - 1];
               end else begin
                  bus.serial_in[s] <= tx_shift[s][3'(BITS - 1) - next_count[3:1]];
               end
            end
         end
         if (host_rise && next_count[0]) begin
            for (int s = 0; s < STREAMS; s++) begin
               rx_shift[s] <= {rx_shift[s][6:0], so_s2[s]};
               if (next_count[3:0] == STEP_LAST) begin
                  rx_data_out[s*BITS +: BITS] <= {rx_shift[s][6:0], so_s2[s]};
               end
            end
            rx_en_acc <= (next_count[3:0] == STEP_FIRST + 4'h1) ? soe_s2 : (rx_en_acc & soe_s2);
            if (next_count[3:0] == STEP_LAST) begin
               rx_enabled_out <= rx_en_acc & soe_s2;
               rx_channel_out <= next_count[8:4];
               rx_valid_out <= 1'b1;
            end
         end
      end
   end

   // processor bus cycle
   assign cmd_ready_out = (state == TSI_HOST_IDLE);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= TSI_HOST_IDLE;
         bus.data_strobe <= 1'b0;
         bus.chip_select_n <= 1'b1;
         bus.read_write <= 1'b1;
         bus.address <= 6'h00;
         bus.host_data <= 8'h00;
         bus.host_data_en <= 1'b0;
         rsp_valid_out <= 1'b0;
         rsp_rdata_out <= 8'h00;
      end else begin
         rsp_valid_out <= 1'b0;
         case (state)
            TSI_HOST_IDLE: begin
               if (cmd_valid_in) begin
                  bus.chip_select_n <= 1'b0;
                  bus.read_write <= ~cmd_write_in;
                  bus.address <= cmd_addr_in;
                  bus.host_data <= cmd_wdata_in;
                  bus.host_data_en <= cmd_write_in;
                  state <= TSI_HOST_SETUP;
               end
            end
            TSI_HOST_SETUP: begin
               bus.data_strobe <= 1'b1;
               state <= TSI_HOST_STROBE;
            end
            TSI_HOST_STROBE: begin
               if (ack_s2) begin
                  rsp_rdata_out <= bus.dev_data;
                  bus.data_strobe <= 1'b0;
                  bus.chip_select_n <= 1'b1;
                  bus.host_data_en <= 1'b0;
                  state <= TSI_HOST_RELEASE;
               end
            end
            TSI_HOST_RELEASE: begin
               if (!ack_s2) begin
                  rsp_valid_out <= 1'b1;
                  state <= TSI_HOST_IDLE;
               end
            end
            default: state <= TSI_HOST_IDLE;
         endcase
      end
   end
endmodule

//--- verif/tsi_switch_asserts.sv
`timescale 1ns/100ps
module tsi_switch_asserts import tsi_pkg::*; #(
   parameter int HALF_CYCLES = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // serial link
   input wire logic frame_pulse_n,
   input wire logic [3:0] serial_out,
   input wire logic [3:0] serial_out_en,
   input wire logic master_drive_enable,
   // processor port
   input wire logic data_strobe,
   input wire logic chip_select_n,
   input wire logic read_write,
   input wire logic [5:0] address,
   input wire logic host_data_en,
   input wire logic dev_data_en,
   input wire logic transfer_ack_n_en
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   logic fp_q;
   logic frame_seen;
   logic frame_fall;
   int gap;
   assign frame_fall = fp_q & ~frame_pulse_n;

   // first frame after reset has no reference edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         fp_q <= 1'b1;
         frame_seen <= 1'b0;
         gap <= 0;
      end else begin
         fp_q <= frame_pulse_n;
         frame_seen <= frame_seen | frame_fall;
         gap <= frame_fall ? 1 : gap + 1;
      end
   end

   a_frame_period: assert property (frame_fall && frame_seen |-> gap == 1024 * HALF_CYCLES)
      else $error("frame pulse spacing wrong");
   a_frame_width: assert property ($fell(frame_pulse_n) |-> !frame_pulse_n [*8] ##1 frame_pulse_n)
      else $error("frame pulse width wrong");
   a_bit_stands: assert property ($changed(serial_out) |=> $stable(serial_out) [*8])
      else $error("serial bit too short");
   a_drive_off: assert property (!master_drive_enable [*5] |-> serial_out_en == 4'h0)
      else $error("output driven while master enable low");
   a_ack_start: assert property ($rose(transfer_ack_n_en) |-> data_strobe && !chip_select_n)
      else $error("acknowledge without request");
   a_ctrl_fast: assert property ($rose(data_strobe) && !chip_select_n && !address[5]
      |-> ##[1:8] transfer_ack_n_en)
      else $error("control access not acknowledged quickly");
   a_mem_bound: assert property ($rose(data_strobe) && !chip_select_n && address[5]
      |-> ##[1:300] transfer_ack_n_en)
      else $error("memory access not acknowledged");
   a_ack_hold: assert property (transfer_ack_n_en && data_strobe && !chip_select_n |=> transfer_ack_n_en)
      else $error("acknowledge dropped early");
   a_ack_release: assert property ($fell(data_strobe) |-> ##[1:6] !transfer_ack_n_en)
      else $error("acknowledge not released");
   a_read_drive: assert property (dev_data_en |-> read_write && transfer_ack_n_en)
      else $error("data bus driven outside read");
   a_one_driver: assert property (!(dev_data_en && host_data_en))
      else $error("data bus contention");

   cover property (frame_fall && frame_seen);
   cover property ($rose(transfer_ack_n_en) && read_write && address[5]);
   cover property (serial_out_en == 4'hF);
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench import tsi_pkg::*; ();
   localparam int HALF = 4;
   localparam int FRAME = 1024 * HALF;
   localparam int NCONN = 9;
   logic clk_in;
   logic reset_in;
   logic cmd_valid, cmd_write, cmd_ready, rsp_valid, drive_enable, slot_start, rx_valid, frame_start;
   logic [5:0] cmd_addr;
   logic [7:0] cmd_wdata, rsp_rdata, control;
   logic [31:0] stream_data, rx_data, sd;
   logic [3:0] rx_enabled;
   logic [4:0] rx_channel, nxt_ch;
   logic [19:0] lfsr;
   logic [7:0] hist [2][4][32];
   logic [8:0] rd_q [$];
   logic [8:0] note;
   int error_cnt, comparisons, cycles, fn, mode;
   // out stream, out channel, low byte, high byte
   // last entry: stream 0 to output 0 must not take the two-slot path
   logic [1:0] c_os [NCONN] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1, 2'h0};
   logic [4:0] c_m [NCONN] = '{5'h06, 5'h14, 5'h0C, 5'h07, 5'h01, 5'h00, 5'h07, 5'h05, 5'h09};
   logic [7:0] c_low [NCONN] = '{8'h04, 8'h04, 8'h2A, 8'h47, 8'h7E, 8'hC3, 8'h24, 8'h04, 8'h07};
   logic [7:0] c_high [NCONN] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'h01};

   tsi_bus_if tsi_bus_if_i ();
   tsi_switch_device tsi_switch_device_i (.clk_in(clk_in), .reset_in(reset_in), .bus(tsi_bus_if_i.device),
      .frame_start_out(frame_start), .control_out(control));
   tsi_switch_host #(.HALF_CYCLES(HALF)) tsi_switch_host_i (.clk_in(clk_in), .reset_in(reset_in),
      .bus(tsi_bus_if_i.host), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr),
      .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata),
      .drive_enable_in(drive_enable), .stream_data_in(stream_data), .slot_start_out(slot_start),
      .rx_data_out(rx_data), .rx_enabled_out(rx_enabled), .rx_channel_out(rx_channel), .rx_valid_out(rx_valid));
   tsi_switch_asserts #(.HALF_CYCLES(HALF)) tsi_switch_asserts_i (.clk_in(clk_in), .reset_in(reset_in),
      .frame_pulse_n(tsi_bus_if_i.frame_pulse_n), .serial_out(tsi_bus_if_i.serial_out),
      .serial_out_en(tsi_bus_if_i.serial_out_en), .master_drive_enable(tsi_bus_if_i.master_drive_enable),
      .data_strobe(tsi_bus_if_i.data_strobe), .chip_select_n(tsi_bus_if_i.chip_select_n),
      .read_write(tsi_bus_if_i.read_write), .address(tsi_bus_if_i.address),
      .host_data_en(tsi_bus_if_i.host_data_en), .dev_data_en(tsi_bus_if_i.dev_data_en),
      .transfer_ack_n_en(tsi_bus_if_i.transfer_ack_n_en));

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   function automatic logic [19:0] lfsr_next(input logic [19:0] x);
      return {x[18:0], x[19] ^ x[16]};
   endfunction

   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: enables %h expected %h", $time, got, exp);
      end
   endtask

   // expectation noted before the request goes out
   task automatic host_cmd(input logic wr, input logic [5:0] addr, input logic [7:0] data, input logic chk,
         input logic [7:0] exp);
      int n;
      n = 0;
      @(negedge clk_in);
      while (cmd_ready !== 1'b1 && n < 2000) begin
         @(negedge clk_in);
         n++;
      end
      rd_q.push_back({chk, exp});
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr <= addr;
      cmd_wdata <= data;
      @(negedge clk_in);
      cmd_valid <= 1'b0;
   endtask

   task automatic check_rx();
      logic [3:0] en_exp;
      logic [7:0] b;
      int f, d;
      en_exp = (mode == 2) ? 4'hF : 4'h0;
      for (int k = 0; k < NCONN; k++) begin
         if (c_m[k] == rx_channel && mode != 0) begin
            b = c_low[k];
            en_exp[c_os[k]] = 1'b1;
            if (mode == 1 && !c_high[k][HIGH_PROC_BIT]) begin
               d = ((b[6:5] == 2'h0 && c_os[k] != 2'h0) || (b[6:5] == 2'h1 && c_os[k] == 2'h3)) ? 2 : 3;
               f = (int'(rx_channel) >= int'(b[4:0]) + d) ? fn : fn - 1;
               b = hist[f % 2][b[6:5]][b[4:0]];
            end
            cmp8(rx_data[8 * c_os[k] +: 8], b);
         end
      end
      cmp4(rx_enabled, en_exp);
   endtask

   always @(negedge clk_in) begin
      if (rsp_valid === 1'b1 && rd_q.size() > 0) begin
         note = rd_q.pop_front();
         if (note[8]) cmp8(rsp_rdata, note[7:0]);
      end
      if (rx_valid === 1'b1 && mode != 3) check_rx();
   end

   // slot 0 starts just before the device reports the frame pulse
   always @(negedge clk_in) begin
      cycles++;
      if (frame_start === 1'b1) begin
         fn++;
         nxt_ch = 5'h01;
      end
      if (slot_start === 1'b1) begin
         for (int s = 0; s < 4; s++) begin
            lfsr = lfsr_next(lfsr);
            sd[8 * s +: 8] = (s == 3) ? {3'h5, nxt_ch} : lfsr[7:0];
            hist[(nxt_ch == 5'h00) ? (fn + 1) % 2 : fn % 2][s][nxt_ch] = sd[8 * s +: 8];
         end
         stream_data <= sd;
         nxt_ch++;
      end
      if (cycles > 90000) begin
         error_cnt++;
         summarize();
      end
   end

   initial begin
      reset_in = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 6'h00;
      cmd_wdata = 8'h00;
      drive_enable = 1'b0;
      stream_data = 32'h0;
      lfsr = 20'h12E9E;
      nxt_ch = 5'h00;
      fn = 0;
      mode = 3;
      error_cnt = 0;
      comparisons = 0;
      cycles = 0;
      repeat (20) @(negedge clk_in);
      reset_in = 1'b0;
      host_cmd(1'b1, 6'h05, 8'h3A, 1'b0, 8'h00);
      host_cmd(1'b0, 6'h1F, 8'h00, 1'b1, 8'h3A);
      cmp8(control, 8'h3A);
      for (int s = 0; s < 4; s++) begin
         host_cmd(1'b1, 6'h00, {3'h0, MS_HIGH, 1'b0, 2'(s)}, 1'b0, 8'h00);
         for (int c = 0; c < 32; c++) host_cmd(1'b1, {1'b1, 5'(c)}, 8'h00, 1'b0, 8'h00);
      end
      mode = 0;
      repeat (FRAME) @(negedge clk_in);
      for (int k = 0; k < NCONN; k++) begin
         host_cmd(1'b1, 6'h00, {3'h0, MS_LOW, 1'b0, c_os[k]}, 1'b0, 8'h00);
         host_cmd(1'b1, {1'b1, c_m[k]}, c_low[k], 1'b0, 8'h00);
         host_cmd(1'b1, 6'h00, {3'h0, MS_HIGH, 1'b0, c_os[k]}, 1'b0, 8'h00);
         host_cmd(1'b1, {1'b1, c_m[k]}, c_high[k], 1'b0, 8'h00);
         host_cmd(1'b0, {1'b1, c_m[k]}, 8'h00, 1'b1, c_high[k]);
      end
      // data memory ignores writes and holds the stream 3 pattern
      host_cmd(1'b1, 6'h00, 8'h0B, 1'b0, 8'h00);
      host_cmd(1'b1, 6'h25, 8'h00, 1'b0, 8'h00);
      host_cmd(1'b0, 6'h25, 8'h00, 1'b1, 8'hA5);
      host_cmd(1'b1, 6'h00, 8'h9B, 1'b0, 8'h00);
      host_cmd(1'b0, 6'h25, 8'h00, 1'b1, 8'hA5);
      host_cmd(1'b1, 6'h2A, 8'h5A, 1'b0, 8'h00);
      host_cmd(1'b1, 6'h00, 8'h13, 1'b0, 8'h00);
      host_cmd(1'b0, 6'h2A, 8'h00, 1'b1, 8'h5A);
      mode = 3;
      drive_enable = 1'b1;
      repeat (FRAME) @(negedge clk_in);
      mode = 1;
      repeat (2 * FRAME) @(negedge clk_in);
      mode = 3;
      host_cmd(1'b1, 6'h00, 8'h40, 1'b0, 8'h00);
      repeat (FRAME) @(negedge clk_in);
      mode = 2;
      repeat (FRAME) @(negedge clk_in);
      mode = 3;
      drive_enable = 1'b0;
      repeat (200) @(negedge clk_in);
      mode = 0;
      repeat (FRAME) @(negedge clk_in);
      summarize();
   end
endmodule
